//--- core/error_record_status.sv
// selected error record status: overflow and misc-valid flags with their context
`timescale 1ns/100ps
`default_nettype none
`include "errrec_defines.svh"
// Notes on behaviour
// R1: repeated error discarded sets overflow flag
// R2: uncorrected set, overflow clear: none discarded
// R3: only deferred set, overflow clear: none discarded
// R4: only corrected: overflow means counter overflowed
// R5: overflow meaningless while record invalid
// R6: software clears overflow when clearing valid
// R7: writing one clears overflow and misc-valid
// R8: both flags reset only by cold reset, not by warm reset
// R9: misc-valid flags extra info in misc words
// R10: misc words tagged by error class
// R11: valid set once any error recorded
// R12: uncorrected flag set on uncorrected error
// R13: deferred flag set on deferred error
// R14: corrected field nonzero once corrected
// R15: writing zero leaves flag unchanged
module error_record_status #(
    parameter int CE_CNT_W = `ERRREC_CE_CNT_W
) (
    // clock, cold reset, warm reset
    input wire logic mclk,
    input wire logic srst,
    input wire logic warm_rst,
    // error events from the node
    input wire logic err_valid,
    input wire errrec_pkg::err_kind_t err_kind,
    input wire logic err_has_misc,
    input wire logic [`ERRREC_MISC_DATA_W-1:0] err_misc_data,
    // system register access to the status register
    input wire logic sysreg_rd_en,
    input wire logic sysreg_wr_en,
    input wire logic [`ERRREC_REG_W-1:0] sysreg_wdata,
    output logic [`ERRREC_REG_W-1:0] sysreg_rdata,
    // access to the misc error words
    input wire logic misc_rd_en,
    input wire logic [1:0] misc_rd_idx,
    output logic [`ERRREC_REG_W-1:0] misc_rdata,
    // live flag view
    output logic discard_overflow_flag,
    output logic misc_info_valid_flag
);
    import errrec_pkg::*;

    logic v_reg, ue_reg, de_reg, of_reg, mv_reg;
    logic [1:0] ce_reg;
    logic [CE_CNT_W-1:0] ce_cnt_reg;
    logic is_unc, is_def, is_cor, first, promote, same_class, recorded, cnt_wrap, of_set;
    logic wr_of, wr_mv;

    function automatic logic w1c(input logic [`ERRREC_REG_W-1:0] d, input int b);
        w1c = sysreg_wr_en && d[b];
    endfunction : w1c

    always_comb begin
        is_unc = err_valid && err_kind == ERR_UNCORRECTED;
        is_def = err_valid && err_kind == ERR_DEFERRED;
        is_cor = err_valid && err_kind == ERR_CORRECTED;
        first = err_valid && !v_reg;
        promote = v_reg && ((is_unc && !ue_reg) || (is_def && !ue_reg && !de_reg));
        same_class = v_reg && ((is_unc && ue_reg) || (is_def && de_reg && !ue_reg)
            || (is_cor && !ue_reg && !de_reg));
        recorded = first || promote || same_class;
        cnt_wrap = is_cor && (&ce_cnt_reg);
        // a second uncorrected or deferred error of the held class, or a corrected counter wrap while no uncorrected or deferred error is held, sets overflow
        of_set = v_reg && ((is_unc && ue_reg) || (is_def && de_reg && !ue_reg)
            || (cnt_wrap && !ue_reg && !de_reg)); // see R1 see R4
        wr_of = w1c(sysreg_wdata, `ERRREC_OF_BIT);
        wr_mv = w1c(sysreg_wdata, `ERRREC_MV_BIT);
    end

    // record valid: set wins over a clearing write
    always_ff @(posedge mclk) begin
        if (srst) begin
            v_reg <= `ERRREC_FLAG_RST;
        end else if (err_valid) begin
            v_reg <= 1'b1; // see R11
        end else if (w1c(sysreg_wdata, `ERRREC_V_BIT)) begin
            v_reg <= 1'b0;
        end
    end

    // error class flags
    always_ff @(posedge mclk) begin
        if (srst) begin
            ue_reg <= `ERRREC_FLAG_RST;
            de_reg <= `ERRREC_FLAG_RST;
        end else begin
            if (is_unc) begin
                ue_reg <= 1'b1; // see R12
            end else if (w1c(sysreg_wdata, `ERRREC_UE_BIT)) begin
                ue_reg <= 1'b0;
            end
            if (is_def) begin
                de_reg <= 1'b1; // see R13
            end else if (w1c(sysreg_wdata, `ERRREC_DE_BIT)) begin
                de_reg <= 1'b0;
            end
        end
    end

    // corrected field and its counter
    always_ff @(posedge mclk) begin
        if (srst) begin
            ce_reg <= `ERRREC_CE_NONE;
            ce_cnt_reg <= '0;
        end else begin
            if (is_cor) begin
                ce_reg <= `ERRREC_CE_SOME; // see R14
            end else if (sysreg_wr_en
                && sysreg_wdata[`ERRREC_CE_HI:`ERRREC_CE_LO] == `ERRREC_CE_CLEAR) begin
                ce_reg <= `ERRREC_CE_NONE;
            end
            if (first && is_cor) begin
                ce_cnt_reg <= CE_CNT_W'(1);
            end else if (first) begin
                ce_cnt_reg <= '0;
            end else if (is_cor) begin
                ce_cnt_reg <= ce_cnt_reg + CE_CNT_W'(1);
            end
        end
    end

    // overflow flag: cold reset only, warm reset ignored
    always_ff @(posedge mclk) begin
        if (srst) begin
            of_reg <= `ERRREC_FLAG_RST; // see R8
        end else if (of_set) begin
            of_reg <= 1'b1; // see R1
        end else if (first || promote) begin
            of_reg <= 1'b0; // see R2 see R3
        end else if (wr_of) begin
            of_reg <= 1'b0; // see R7
        end
    end // see R15

    // misc-valid flag
    always_ff @(posedge mclk) begin
        if (srst) begin
            mv_reg <= `ERRREC_FLAG_RST; // see R8
        end else if (recorded && err_has_misc) begin
            mv_reg <= 1'b1; // see R9
        end else if (first) begin
            mv_reg <= 1'b0; // see R9
        end else if (wr_mv) begin
            mv_reg <= 1'b0; // see R7
        end
    end // see R15

    // read view; flags of an invalid record read as zero
    always_ff @(posedge mclk) begin
        if (srst || warm_rst) begin
            sysreg_rdata <= '0;
        end else if (sysreg_rd_en) begin
            sysreg_rdata <= '0;
            sysreg_rdata[`ERRREC_V_BIT] <= v_reg;
            sysreg_rdata[`ERRREC_UE_BIT] <= v_reg && ue_reg;
            sysreg_rdata[`ERRREC_OF_BIT] <= v_reg && of_reg; // see R5
            sysreg_rdata[`ERRREC_MV_BIT] <= v_reg && mv_reg;
            sysreg_rdata[`ERRREC_CE_HI:`ERRREC_CE_LO] <= v_reg ? ce_reg : `ERRREC_CE_NONE;
            sysreg_rdata[`ERRREC_DE_BIT] <= v_reg && de_reg;
        end
    end

    assign discard_overflow_flag = of_reg;
    assign misc_info_valid_flag = mv_reg;

    // one slot per error class, class code in the top bits
    misc_info_store #(
        .DEPTH(`ERRREC_MISC_DEPTH),
        .WIDTH(`ERRREC_REG_W)
    ) misc_info_store_i (
        .mclk(mclk),
        .srst(srst),
        .wr_en(recorded && err_has_misc), // see R10
        .wr_idx(err_kind),
        .wr_data({err_kind, err_misc_data}),
        .rd_en(misc_rd_en),
        .rd_idx(misc_rd_idx),
        .rd_data(misc_rdata)
    );

    sequence s_repeat_unc;
        err_valid && err_kind == ERR_UNCORRECTED && v_reg && ue_reg;
    endsequence

    sequence s_clear_of_quiet;
        sysreg_wr_en && sysreg_wdata[`ERRREC_OF_BIT] && !err_valid;
    endsequence

    AST_OF_ON_REPEAT: assert property (@(posedge mclk) disable iff (srst) // see R1
        s_repeat_unc |=> of_reg ##1 (of_reg || $past(wr_of)))
        else $error("overflow not set by repeated uncorrected error");
    AST_OF_CLEAR_FIRST: assert property (@(posedge mclk) disable iff (srst) // see R2
        (err_valid && !v_reg) |=> !of_reg && v_reg)
        else $error("overflow set on first recorded error");
    AST_OF_PROMOTE: assert property (@(posedge mclk) disable iff (srst) // see R3
        (is_def && v_reg && !ue_reg && !de_reg) |=> !of_reg && de_reg)
        else $error("overflow kept after promotion to deferred");
    AST_CE_WRAP: assert property (@(posedge mclk) disable iff (srst) // see R4
        (cnt_wrap && v_reg && !ue_reg && !de_reg) |=> of_reg && ce_cnt_reg == '0)
        else $error("corrected counter wrap did not raise overflow");
    AST_READ_MASK: assert property (@(posedge mclk) disable iff (srst || warm_rst) // see R5
        (sysreg_rd_en && !v_reg) |=> sysreg_rdata[`ERRREC_OF_BIT] == 1'b0)
        else $error("overflow visible while record invalid");
    AST_W1C: assert property (@(posedge mclk) disable iff (srst) // see R7
        s_clear_of_quiet |=> !of_reg)
        else $error("write one did not clear overflow");
    AST_WARM_KEEP: assert property (@(posedge mclk) disable iff (srst) // see R8
        (warm_rst && !err_valid && !sysreg_wr_en) |=> $stable({of_reg, mv_reg}))
        else $error("warm reset disturbed flags");
    AST_MV_SET: assert property (@(posedge mclk) disable iff (srst) // see R9
        (err_valid && !v_reg && err_has_misc) |=> mv_reg ##1 (mv_reg || $past(wr_mv)))
        else $error("misc-valid not set for recorded error");
    AST_WRITE_ZERO: assert property (@(posedge mclk) disable iff (srst) // see R15
        (sysreg_wr_en && !sysreg_wdata[`ERRREC_OF_BIT] && !sysreg_wdata[`ERRREC_MV_BIT]
        && !err_valid) |=> $stable(of_reg) && $stable(mv_reg))
        else $error("write of zero changed a flag");
    AST_UE_SET: assert property (@(posedge mclk) disable iff (srst) // see R12
        is_unc |=> ue_reg && v_reg)
        else $error("uncorrected flag not set");
endmodule : error_record_status
`default_nettype wire

//--- core/errrec_defines.svh
// bit positions, reset values and widths of the selected error record status register
`ifndef ERRREC_DEFINES_SVH
`define ERRREC_DEFINES_SVH

`define ERRREC_REG_W 64
`define ERRREC_V_BIT 30
`define ERRREC_UE_BIT 29
`define ERRREC_OF_BIT 27
`define ERRREC_MV_BIT 26
`define ERRREC_CE_HI 25
`define ERRREC_CE_LO 24
`define ERRREC_DE_BIT 23
`define ERRREC_CE_NONE 2'h0
`define ERRREC_CE_SOME 2'h2
`define ERRREC_CE_CLEAR 2'h3
`define ERRREC_FLAG_RST 1'h0
`define ERRREC_CE_CNT_W 8
`define ERRREC_MISC_DEPTH 3
`define ERRREC_MISC_DATA_W 62

`endif

//--- core/errrec_pkg.sv
// types shared by the error record status logic
`default_nettype none
package errrec_pkg;
    typedef enum logic [1:0] {
        ERR_CORRECTED,
        ERR_DEFERRED,
        ERR_UNCORRECTED
    } err_kind_t;
endpackage : errrec_pkg
`default_nettype wire

//--- core/misc_info_store.sv
// small store for the per-class miscellaneous error words
`timescale 1ns/100ps
`default_nettype none
`include "errrec_defines.svh"
module misc_info_store #(
    parameter int DEPTH = `ERRREC_MISC_DEPTH,
    parameter int WIDTH = `ERRREC_REG_W
) (
    // clock and cold reset
    input wire logic mclk,
    input wire logic srst,
    // write side
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    // read side
    input wire logic rd_en,
    input wire logic [1:0] rd_idx,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_word
            always_ff @(posedge mclk) begin
                if (srst) begin
                    mem_reg[i] <= '0;
                end else if (wr_en && wr_idx == 2'(i)) begin
                    mem_reg[i] <= wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= (32'(rd_idx) < DEPTH) ? mem_reg[rd_idx] : '0;
        end
    end
endmodule : misc_info_store
`default_nettype wire

//--- testbench/error_record_status_tb.sv
// self-checking bench for the error record status flags
`timescale 1ns/100ps
`default_nettype none
`include "errrec_defines.svh"
module error_record_status_tb;
    import errrec_pkg::*;
    localparam logic [63:0] V_M = 64'h4000_0000;
    localparam logic [63:0] UE_M = 64'h2000_0000;
    localparam logic [63:0] OF_M = 64'h0800_0000;
    localparam logic [63:0] MV_M = 64'h0400_0000;
    localparam logic [63:0] CE_M = 64'h0200_0000;
    localparam logic [63:0] DE_M = 64'h0080_0000;
    localparam logic [63:0] ALL_M = 64'h6f80_0000;
    localparam logic [61:0] MDATA = 62'h2345_6789_abcd_ef01;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic warm_rst = 1'b0;
    logic err_valid = 1'b0;
    err_kind_t err_kind = ERR_CORRECTED;
    logic err_has_misc = 1'b0;
    logic [61:0] err_misc_data = '0;
    logic sysreg_rd_en = 1'b0;
    logic sysreg_wr_en = 1'b0;
    logic [63:0] sysreg_wdata = '0;
    logic [63:0] sysreg_rdata;
    logic misc_rd_en = 1'b0;
    logic [1:0] misc_rd_idx = 2'h0;
    logic [63:0] misc_rdata;
    logic discard_overflow_flag;
    logic misc_info_valid_flag;
    logic [63:0] v;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;

    error_record_status #(.CE_CNT_W(2)) error_record_status_i (
        .mclk(mclk), .srst(srst), .warm_rst(warm_rst),
        .err_valid(err_valid), .err_kind(err_kind), .err_has_misc(err_has_misc),
        .err_misc_data(err_misc_data), .sysreg_rd_en(sysreg_rd_en),
        .sysreg_wr_en(sysreg_wr_en), .sysreg_wdata(sysreg_wdata),
        .sysreg_rdata(sysreg_rdata), .misc_rd_en(misc_rd_en), .misc_rd_idx(misc_rd_idx),
        .misc_rdata(misc_rdata), .discard_overflow_flag(discard_overflow_flag),
        .misc_info_valid_flag(misc_info_valid_flag)
    );

    always #5 mclk = ~mclk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic chk_word(input string name, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic chk_flag(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_flag

    task automatic rd_status(output logic [63:0] d);
        @(negedge mclk) sysreg_rd_en = 1'b1;
        @(negedge mclk) sysreg_rd_en = 1'b0;
        d = sysreg_rdata;
    endtask : rd_status

    task automatic wr_status(input logic [63:0] d);
        @(negedge mclk);
        sysreg_wr_en = 1'b1;
        sysreg_wdata = d;
        @(negedge mclk);
        sysreg_wr_en = 1'b0;
        sysreg_wdata = '0;
    endtask : wr_status

    task automatic raise(input err_kind_t k, input logic m, input logic [61:0] d);
        @(negedge mclk);
        err_valid = 1'b1;
        err_kind = k;
        err_has_misc = m;
        err_misc_data = d;
        @(negedge mclk) err_valid = 1'b0;
    endtask : raise

    task automatic t_reset();
        rd_status(v);
        chk_word("status after reset", 64'h0, v);
        chk_flag("overflow after reset", 1'b0, discard_overflow_flag);
    endtask : t_reset

    task automatic t_uncorrected();
        raise(ERR_UNCORRECTED, 1'b1, MDATA);
        rd_status(v);
        chk_word("first uncorrected", V_M | UE_M | MV_M, v);
        @(negedge mclk);
        misc_rd_en = 1'b1;
        misc_rd_idx = 2'h2;
        @(negedge mclk) misc_rd_en = 1'b0;
        chk_word("misc word", {2'h2, MDATA}, misc_rdata);
        raise(ERR_UNCORRECTED, 1'b0, '0);
        rd_status(v);
        chk_word("second uncorrected", V_M | UE_M | MV_M | OF_M, v);
        wr_status(64'h0);
        chk_flag("overflow after zero write", 1'b1, discard_overflow_flag);
        @(negedge mclk) warm_rst = 1'b1;
        @(negedge mclk) warm_rst = 1'b0;
        chk_flag("overflow after warm reset", 1'b1, discard_overflow_flag);
        chk_flag("misc valid after warm reset", 1'b1, misc_info_valid_flag);
        wr_status(V_M);
        rd_status(v);
        chk_word("invalid record masked", 64'h0, v);
        chk_flag("overflow kept by valid clear", 1'b1, discard_overflow_flag);
        wr_status(OF_M);
        chk_flag("overflow after clear", 1'b0, discard_overflow_flag);
        chk_flag("misc valid kept", 1'b1, misc_info_valid_flag);
        wr_status(MV_M);
        chk_flag("misc valid after clear", 1'b0, misc_info_valid_flag);
    endtask : t_uncorrected

    task automatic t_deferred();
        wr_status(ALL_M);
        rd_status(v);
        chk_word("status after full clear", 64'h0, v);
        raise(ERR_DEFERRED, 1'b0, '0);
        rd_status(v);
        chk_word("deferred only", V_M | DE_M, v);
    endtask : t_deferred

    task automatic t_corrected();
        wr_status(ALL_M);
        raise(ERR_CORRECTED, 1'b0, '0);
        rd_status(v);
        chk_word("corrected only", V_M | CE_M, v);
        // four events wrap a two-bit counter whichever count it starts from
        repeat (4) raise(ERR_CORRECTED, 1'b0, '0);
        chk_flag("counter overflow", 1'b1, discard_overflow_flag);
        raise(ERR_DEFERRED, 1'b0, '0);
        rd_status(v);
        chk_word("promoted to deferred", V_M | CE_M | DE_M, v);
        raise(ERR_DEFERRED, 1'b1, MDATA);
        chk_flag("repeated deferred", 1'b1, discard_overflow_flag);
        chk_flag("misc valid on repeat", 1'b1, misc_info_valid_flag);
    endtask : t_corrected

    task automatic t_cold();
        @(negedge mclk) srst = 1'b1;
        @(negedge mclk) srst = 1'b0;
        chk_flag("overflow after cold reset", 1'b0, discard_overflow_flag);
        chk_flag("misc valid after cold reset", 1'b0, misc_info_valid_flag);
        rd_status(v);
        chk_word("status after cold reset", 64'h0, v);
    endtask : t_cold

    initial begin
        repeat (10) @(negedge mclk);
        srst = 1'b0;
        t_reset();
        t_uncorrected();
        t_deferred();
        t_corrected();
        t_cold();
        finish_test();
    end
endmodule : error_record_status_tb
`default_nettype wire
